//--- pkg/pasr_pkg.sv
package pasr_pkg;

    // Bus geometry.
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned DC_WIDTH = 7;

    // Register byte addresses.
    localparam logic [ADDR_W-1:0] OFF_DEL  = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_ASD  = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_IST  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_IMSK = 8'h0C;

    // Reset values.
    localparam logic [7:0] DEL_RST  = 8'h00;
    localparam logic [7:0] ASD_RST  = 8'h00;
    localparam logic [1:0] IRQ_RST  = 2'h0;

    // Field positions.
    localparam int unsigned RSEN_BIT = 7;
    localparam int unsigned ASE_BIT  = 7;
    localparam int unsigned SRC_LSB  = 4;
    localparam int unsigned AC_LSB   = 2;
    localparam int unsigned BD_LSB   = 0;
    localparam int unsigned IRQ_W    = 2;
    localparam int unsigned IRQ_SD   = 0;
    localparam int unsigned IRQ_RS   = 1;

    // Shutdown source select bits: comparator 1, comparator 2, fault pin.
    localparam logic [2:0] SRC_NONE = 3'h0;

    // Shutdown level codes for a pin pair.
    localparam logic [1:0] LVL_LOW  = 2'h0;
    localparam logic [1:0] LVL_HIGH = 2'h1;

    typedef enum logic [4:0] {
        SEL_NONE = 5'b00001,
        SEL_DEL  = 5'b00010,
        SEL_ASD  = 5'b00100,
        SEL_IST  = 5'b01000,
        SEL_IMSK = 5'b10000
    } pasr_sel_t;

    typedef enum logic [1:0] {
        MODE_RUN  = 2'b01,
        MODE_SHUT = 2'b10
    } pasr_mode_t;

endpackage

//--- pkg/pasr_db_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pasr_db_if #(
    parameter int unsigned DC_W = 7
);
    logic [1:0]      raw;
    logic [DC_W-1:0] count;
    logic [1:0]      dly;

    modport ctl (output raw, output count, input dly);
    modport dbu (input raw, input count, output dly);
endinterface
`default_nettype wire

//--- rtl/pasr_deadband.sv
`timescale 1ns/1ps
`default_nettype none
module pasr_deadband #(
    parameter int unsigned DC_W = 7
)(
    // Clock and reset
    input  wire logic   pclk,
    input  wire logic   presetn,
    // Delay channels
    pasr_db_if.dbu      db
);
    logic [DC_W-1:0] cnt_q [2];
    logic [1:0]      dly_q;

    // The counter saturates so a long high phase cannot wrap and drop out.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q[0] <= '0;
            cnt_q[1] <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!db.raw[i]) begin
                    cnt_q[i] <= '0;
                end else if (cnt_q[i] != '1) begin
                    cnt_q[i] <= cnt_q[i] + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_q <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                dly_q[i] <= db.raw[i] && (cnt_q[i] >= db.count);
            end
        end
    end

    assign db.dly = dly_q;

    property p_db_rise;
        @(posedge pclk) disable iff (!presetn)
        db.raw[0] && cnt_q[0] == db.count |=> dly_q[0];
    endproperty
    a_db_rise: assert property (p_db_rise)
        else $error("Delayed output did not rise after dead band.");

    property p_db_short;
        @(posedge pclk) disable iff (!presetn)
        cnt_q[1] < db.count |=> !dly_q[1];
    endproperty
    a_db_short: assert property (p_db_short)
        else $error("Delayed output rose before dead band elapsed.");

    property p_db_fall;
        @(posedge pclk) disable iff (!presetn)
        !db.raw[0] ##1 !db.raw[0] |-> !dly_q[0];
    endproperty
    a_db_fall: assert property (p_db_fall)
        else $error("Falling edge was delayed.");
endmodule
`default_nettype wire

//--- rtl/pasr_top.sv
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Restart enable set: flag clears itself once the shutdown cause is gone.
// - Restart enable clear: flag stays set until software clears it.
// - Inactive-to-active edges of outputs A and B are delayed by the dead-band count in cycles.
// - Source field picks comparator 1, comparator 2, fault pin, any mix.
// - During shutdown pair A/C drives low, high, or floats per bits 3-2.
// - During shutdown pair B/D drives low, high, or floats per bits 1-0.
// - With restart enabled the flag stays set while the cause persists.
// - Normal output resumes only at the next period start.
// - Software writes to the flag are ignored while a cause is active.
// - Comparator causes act as levels; flag cannot clear while present.
// - Writing one to the flag forces shutdown like a hardware event.
// - A shutdown event sets the flag and moves pins at once.
// - Flag set at period start holds shutdown for the whole period.
// - Dead band longer than the high time keeps that output inactive.
module pasr_top
    import pasr_pkg::*;
#(
    parameter int unsigned DC_W = DC_WIDTH
)(
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    // PWM stage
    input  wire logic              pwm_a,
    input  wire logic              pwm_b,
    input  wire logic              pwm_c,
    input  wire logic              pwm_d,
    input  wire logic              period_start,
    input  wire logic              half_bridge,
    // Shutdown sources
    input  wire logic              comp1_out,
    input  wire logic              comp2_out,
    input  wire logic              fault_input_pin,
    // Output pins
    output logic                   output_a,
    output logic                   output_b,
    output logic                   output_c,
    output logic                   output_d,
    output logic                   output_a_oe,
    output logic                   output_b_oe,
    output logic                   output_c_oe,
    output logic                   output_d_oe,
    // Interrupt
    output logic                   irq
);

    if (DC_W < 1 || DC_W > 7) begin : g_bad_dc_w
        $error("DC_W must lie between 1 and 7.");
    end

    function automatic pasr_sel_t reg_sel(input logic [ADDR_W-1:0] a);
        if (a == OFF_DEL) begin
            return SEL_DEL;
        end else if (a == OFF_ASD) begin
            return SEL_ASD;
        end else if (a == OFF_IST) begin
            return SEL_IST;
        end else if (a == OFF_IMSK) begin
            return SEL_IMSK;
        end else begin
            return SEL_NONE;
        end
    endfunction

    function automatic logic cause_of(input logic [2:0] sel,
                                      input logic [2:0] src);
        return |(sel & src);
    endfunction

    // Returns output enable and level for one pin pair in shutdown.
    function automatic logic [1:0] lvl_of(input logic [1:0] code);
        if (code[1]) begin
            return 2'h0;
        end else begin
            return {1'b1, code[0]};
        end
    endfunction

    logic [7:0]        del_q;
    logic [6:0]        asd_q;
    logic              sd_q;
    logic              sd_d;
    logic [IRQ_W-1:0]  ist_q;
    logic [IRQ_W-1:0]  ist_d;
    logic [IRQ_W-1:0]  imsk_q;
    logic [IRQ_W-1:0]  evt;
    logic [2:0]        sync1_q;
    logic [2:0]        sync2_q;
    pasr_mode_t        mode_q;
    pasr_mode_t        mode_d;
    pasr_sel_t         sel;
    logic              setup;
    logic              wr;
    logic              wr_asd;
    logic              sw_set;
    logic              sw_clr;
    logic              cause_raw;
    logic              cause_syn;
    logic              cause_any;
    logic [DATA_W-1:0] rd_val;
    logic [DATA_W-1:0] prdata_q;
    logic              pready_q;
    logic              pslverr_q;
    logic [3:0]        out_q;
    logic [3:0]        oe_q;
    logic              irq_q;
    logic [1:0]        ac_lvl;
    logic [1:0]        bd_lvl;

    pasr_db_if #(.DC_W(DC_W)) db ();

    pasr_deadband #(.DC_W(DC_W)) u_deadband (
        .pclk    (pclk),
        .presetn (presetn),
        .db      (db)
    );

    // Outside half-bridge mode the delay is bypassed but the latency kept.
    assign db.raw   = {pwm_b, pwm_a};
    assign db.count = half_bridge ? del_q[DC_W-1:0] : '0;

    // APB decode; one access cycle, no wait states.
    assign sel    = reg_sel(paddr);
    assign setup  = psel && !penable;
    assign wr     = psel && penable && pwrite && pready_q;
    assign wr_asd = wr && (sel == SEL_ASD);
    assign sw_set = wr_asd && pwdata[ASE_BIT];
    assign sw_clr = wr_asd && !pwdata[ASE_BIT];

    always_comb begin
        rd_val = '0;
        case (sel)
            SEL_DEL:  rd_val[7:0] = del_q;
            SEL_ASD:  rd_val[7:0] = {sd_q, asd_q};
            SEL_IST:  rd_val[IRQ_W-1:0] = ist_q;
            SEL_IMSK: rd_val[IRQ_W-1:0] = imsk_q;
            default:  rd_val = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && (sel == SEL_NONE);
            if (setup) begin
                prdata_q <= pwrite ? '0 : rd_val;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            del_q  <= DEL_RST;
            asd_q  <= ASD_RST[6:0];
            imsk_q <= IRQ_RST;
        end else if (wr) begin
            if (sel == SEL_DEL) begin
                del_q <= pwdata[7:0];
            end
            if (sel == SEL_ASD) begin
                asd_q <= pwdata[6:0];
            end
            if (sel == SEL_IMSK) begin
                imsk_q <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // The second stage only is read; the first stage may be metastable.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= {fault_input_pin, comp2_out, comp1_out};
            sync2_q <= sync1_q;
        end
    end

    // The raw sources may set the flag at once; only a cause absent from
    // both raw and synchronised copies lets it clear.
    assign cause_raw = cause_of(asd_q[SRC_LSB+:3],
                                {fault_input_pin, comp2_out, comp1_out});
    assign cause_syn = cause_of(asd_q[SRC_LSB+:3], sync2_q);
    assign cause_any = cause_raw || cause_syn;

    always_comb begin
        sd_d = sd_q;
        if (del_q[RSEN_BIT] && !cause_any) begin
            sd_d = 1'b0;
        end
        if (sw_clr && !cause_any) begin
            sd_d = 1'b0;
        end
        if (cause_any || sw_set) begin
            sd_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sd_q <= 1'b0;
        end else begin
            sd_q <= sd_d;
        end
    end

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            MODE_RUN: begin
                if (sd_d) begin
                    mode_d = MODE_SHUT;
                end
            end
            MODE_SHUT: begin
                if (period_start && !sd_q && !sd_d) begin
                    mode_d = MODE_RUN;
                end
            end
            default: mode_d = MODE_SHUT;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= MODE_RUN;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Pins follow the next mode so they change on the same edge as the flag.
    assign ac_lvl = lvl_of(asd_q[AC_LSB+:2]);
    assign bd_lvl = lvl_of(asd_q[BD_LSB+:2]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= 4'h0;
            oe_q  <= 4'h0;
        end else if (mode_d == MODE_SHUT) begin
            out_q <= {bd_lvl[0], ac_lvl[0], bd_lvl[0], ac_lvl[0]};
            oe_q  <= {bd_lvl[1], ac_lvl[1], bd_lvl[1], ac_lvl[1]};
        end else begin
            out_q <= {pwm_d, pwm_c, db.dly[1], db.dly[0]};
            oe_q  <= 4'hF;
        end
    end

    // Set wins over a write-one-to-clear in the same cycle.
    assign evt[IRQ_SD] = sd_d && !sd_q;
    assign evt[IRQ_RS] = (mode_q == MODE_SHUT) && (mode_d == MODE_RUN);
    assign ist_d = (ist_q & ~((wr && sel == SEL_IST) ?
                   pwdata[IRQ_W-1:0] : {IRQ_W{1'b0}})) | evt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_q <= IRQ_RST;
            irq_q <= 1'b0;
        end else begin
            ist_q <= ist_d;
            irq_q <= |(ist_d & imsk_q);
        end
    end

    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign output_a    = out_q[0];
    assign output_b    = out_q[1];
    assign output_c    = out_q[2];
    assign output_d    = out_q[3];
    assign output_a_oe = oe_q[0];
    assign output_b_oe = oe_q[1];
    assign output_c_oe = oe_q[2];
    assign output_d_oe = oe_q[3];
    assign irq         = irq_q;

    property p_auto_clr;
        @(posedge pclk) disable iff (!presetn)
        sd_q && del_q[RSEN_BIT] && !cause_any && !sw_set |=> !sd_q;
    endproperty
    a_auto_clr: assert property (p_auto_clr)
        else $error("Flag did not clear automatically.");

    property p_manual_hold;
        @(posedge pclk) disable iff (!presetn)
        sd_q && !del_q[RSEN_BIT] && !wr_asd |=> sd_q;
    endproperty
    a_manual_hold: assert property (p_manual_hold)
        else $error("Flag cleared without software.");

    property p_src_off;
        @(posedge pclk) disable iff (!presetn)
        asd_q[SRC_LSB+:3] == SRC_NONE && !sd_q && !sw_set |=> !sd_q;
    endproperty
    a_src_off: assert property (p_src_off)
        else $error("Shutdown with no source selected.");

    property p_ac_low;
        @(posedge pclk) disable iff (!presetn)
        mode_d == MODE_SHUT && asd_q[AC_LSB+:2] == LVL_LOW
        |=> output_a_oe && output_c_oe && !output_a && !output_c;
    endproperty
    a_ac_low: assert property (p_ac_low)
        else $error("Pair A/C not driven low in shutdown.");

    property p_bd_high;
        @(posedge pclk) disable iff (!presetn)
        mode_d == MODE_SHUT && asd_q[BD_LSB+:2] == LVL_HIGH
        |=> output_b_oe && output_d_oe && output_b && output_d;
    endproperty
    a_bd_high: assert property (p_bd_high)
        else $error("Pair B/D not driven high in shutdown.");

    property p_cause_hold;
        @(posedge pclk) disable iff (!presetn)
        cause_any |=> sd_q;
    endproperty
    a_cause_hold: assert property (p_cause_hold)
        else $error("Flag clear while cause present.");

    property p_resume;
        @(posedge pclk) disable iff (!presetn)
        $fell(mode_q == MODE_SHUT) |-> $past(period_start);
    endproperty
    a_resume: assert property (p_resume)
        else $error("Output resumed mid-period.");

    property p_wr_ignored;
        @(posedge pclk) disable iff (!presetn)
        sw_clr && cause_syn |=> sd_q;
    endproperty
    a_wr_ignored: assert property (p_wr_ignored)
        else $error("Flag write accepted during shutdown cause.");

    property p_comp_level;
        @(posedge pclk) disable iff (!presetn)
        (|(asd_q[SRC_LSB+:2] & sync2_q[1:0])) [*2] |-> sd_q ##1 sd_q;
    endproperty
    a_comp_level: assert property (p_comp_level)
        else $error("Comparator level did not hold the flag.");

    property p_force;
        @(posedge pclk) disable iff (!presetn)
        sw_set |=> sd_q && mode_q == MODE_SHUT;
    endproperty
    a_force: assert property (p_force)
        else $error("Forced shutdown did not take effect.");

    property p_event;
        @(posedge pclk) disable iff (!presetn)
        cause_raw |=> sd_q && mode_q == MODE_SHUT
                      && (ist_q[IRQ_SD] || $past(sd_q));
    endproperty
    a_event: assert property (p_event)
        else $error("Shutdown event not taken at once.");

    property p_period_hold;
        @(posedge pclk) disable iff (!presetn)
        period_start && sd_q |=> mode_q == MODE_SHUT;
    endproperty
    a_period_hold: assert property (p_period_hold)
        else $error("Shutdown not held for the period.");
endmodule
`default_nettype wire

//--- tb/pasr_bridge_model.sv
`timescale 1ns/1ps
`default_nettype none
// Gate drivers of the bridge; a weak pull-down on each input keeps a
// floating pin low, so a released pin never turns a switch on.
module pasr_bridge_model (
    // Pins from the block
    input  wire logic [3:0] pin,
    input  wire logic [3:0] pin_oe,
    // Levels seen by the switch drivers
    output logic      [3:0] gate
);
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            gate[i] = pin_oe[i] ? pin[i] : 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pasr_pkg::*;
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              pwm_a = 1'b0;
    logic              pwm_b = 1'b0;
    logic              period_start = 1'b0;
    logic              half_bridge = 1'b0;
    logic [2:0]        cause = 3'h0;
    logic [3:0]        pin;
    logic [3:0]        pin_oe;
    logic [3:0]        gate;
    logic              irq;
    int                fails = 0;
    int                comparisons = 0;
    int                cycles = 0;

    always #50 pclk = ~pclk;

    pasr_top i_pasr_top (
        .pclk            (pclk),
        .presetn         (presetn),
        .paddr           (paddr),
        .psel            (psel),
        .penable         (penable),
        .pwrite          (pwrite),
        .pwdata          (pwdata),
        .prdata          (prdata),
        .pready          (pready),
        .pslverr         (pslverr),
        .pwm_a           (pwm_a),
        .pwm_b           (pwm_b),
        .pwm_c           (pwm_a),
        .pwm_d           (pwm_b),
        .period_start    (period_start),
        .half_bridge     (half_bridge),
        .comp1_out       (cause[0]),
        .comp2_out       (cause[1]),
        .fault_input_pin (cause[2]),
        .output_a        (pin[0]),
        .output_b        (pin[1]),
        .output_c        (pin[2]),
        .output_d        (pin[3]),
        .output_a_oe     (pin_oe[0]),
        .output_b_oe     (pin_oe[1]),
        .output_c_oe     (pin_oe[2]),
        .output_d_oe     (pin_oe[3]),
        .irq             (irq)
    );

    pasr_bridge_model i_pasr_bridge_model (
        .pin    (pin),
        .pin_oe (pin_oe),
        .gate   (gate)
    );

    task automatic end_sim();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // A hang counts as a mismatch; the whole run needs about 600 cycles.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input logic exp_err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, exp_err});
    endtask

    task automatic new_period();
        period_start <= 1'b1;
        cyc(1);
        period_start <= 1'b0;
        cyc(2);
    endtask

    task automatic t_reset_values();
        rd(OFF_DEL, 32'h0000_0000, 1'b0);
        rd(OFF_ASD, 32'h0000_0000, 1'b0);
        rd(OFF_IST, 32'h0000_0000, 1'b0);
        rd(OFF_IMSK, 32'h0000_0000, 1'b0);
        rd(8'h10, 32'h0000_0000, 1'b1);
    endtask

    // Fault pin with restart enabled; A/C forced high, B/D released.
    task automatic t_auto_restart();
        wr(OFF_DEL, 32'h0000_0080);
        wr(OFF_ASD, 32'h0000_0046);
        cause[2] <= 1'b1;
        cyc(2);
        chk({28'h0, pin}, 32'h0000_0005);
        chk({28'h0, pin_oe}, 32'h0000_0005);
        chk({28'h0, gate}, 32'h0000_0005);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(OFF_IMSK, 32'h0000_0003);
        cyc(2);
        chk({31'h0, irq}, 32'h0000_0001);
        rd(OFF_ASD, 32'h0000_00C6, 1'b0);
        cause[2] <= 1'b0;
        cyc(6);
        rd(OFF_ASD, 32'h0000_0046, 1'b0);
        chk({28'h0, pin_oe}, 32'h0000_0005);
        new_period();
        chk({28'h0, pin_oe}, 32'h0000_000F);
        chk({28'h0, pin}, 32'h0000_0000);
        rd(OFF_IST, 32'h0000_0003, 1'b0);
        wr(OFF_IST, 32'h0000_0003);
        cyc(2);
        chk({31'h0, irq}, 32'h0000_0000);
    endtask

    // Comparator cause without restart: flag held by hardware and software.
    task automatic t_manual_restart();
        wr(OFF_DEL, 32'h0000_0000);
        wr(OFF_ASD, 32'h0000_0010);
        cause[0] <= 1'b1;
        cyc(3);
        wr(OFF_ASD, 32'h0000_0010);
        rd(OFF_ASD, 32'h0000_0090, 1'b0);
        cause[0] <= 1'b0;
        cyc(6);
        rd(OFF_ASD, 32'h0000_0090, 1'b0);
        wr(OFF_ASD, 32'h0000_0010);
        rd(OFF_ASD, 32'h0000_0010, 1'b0);
        new_period();
    endtask

    // Every source code against every single cause.
    task automatic t_sources();
        logic [2:0] s;
        wr(OFF_DEL, 32'h0000_0080);
        for (int i = 0; i < 8; i++) begin
            s = 3'(i);
            for (int c = 0; c < 3; c++) begin
                wr(OFF_ASD, {25'h0, s, 4'h0});
                cause[c] <= 1'b1;
                cyc(3);
                rd(OFF_ASD, {24'h0, s[c], s, 4'h0}, 1'b0);
                cause[c] <= 1'b0;
                cyc(6);
                rd(OFF_ASD, {25'h0, s, 4'h0}, 1'b0);
            end
        end
        wr(OFF_ASD, 32'h0000_0000);
        new_period();
    endtask

    // Software force with no source selected; both pairs driven high.
    task automatic t_force();
        wr(OFF_DEL, 32'h0000_0000);
        wr(OFF_ASD, 32'h0000_0085);
        cyc(2);
        chk({28'h0, pin}, 32'h0000_000F);
        new_period();
        chk({28'h0, pin}, 32'h0000_000F);
        wr(OFF_ASD, 32'h0000_0005);
        new_period();
        chk({28'h0, pin}, 32'h0000_0000);
    endtask

    // Dead band of three cycles on a rising edge, then a shorter pulse.
    task automatic t_dead_band();
        wr(OFF_DEL, 32'h0000_0003);
        half_bridge <= 1'b1;
        cyc(2);
        pwm_a <= 1'b1;
        cyc(4);
        chk({31'h0, pin[0]}, 32'h0000_0000);
        chk({31'h0, pin[2]}, 32'h0000_0001);
        cyc(1);
        chk({31'h0, pin[0]}, 32'h0000_0001);
        pwm_a <= 1'b0;
        cyc(3);
        pwm_a <= 1'b1;
        repeat (2) begin
            cyc(1);
            chk({31'h0, pin[0]}, 32'h0000_0000);
        end
        pwm_a <= 1'b0;
        repeat (4) begin
            cyc(1);
            chk({31'h0, pin[0]}, 32'h0000_0000);
        end
        pwm_b <= 1'b1;
        cyc(4);
        chk({31'h0, pin[1]}, 32'h0000_0000);
        cyc(1);
        chk({31'h0, pin[1]}, 32'h0000_0001);
        pwm_b <= 1'b0;
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_values();
        t_auto_restart();
        t_manual_restart();
        t_sources();
        t_force();
        t_dead_band();
        end_sim();
    end
endmodule
`default_nettype wire
